//--- common/cascade_counter_consts.vh
`ifndef CASCADE_COUNTER_CONSTS_VH
`define CASCADE_COUNTER_CONSTS_VH
// ********************************************
// register word indices on the 4-bit address port
// ********************************************
`define ADDR_MODE_CTRL 4'h0
`define ADDR_CLK_SEL 4'h1
`define ADDR_OUT_CTRL 4'h2
`define ADDR_LOW_CMP 4'h3
`define ADDR_HIGH_CMP 4'h4
`define ADDR_COUNT 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_FAST_CLK 4'h7
// ********************************************
// field positions
// ********************************************
`define BIT_COUNT_ENABLE 0
`define BIT_CASCADE_MODE 2
`define BIT_HIGH_OUT_EN 4
`define BIT_LOW_OUT_EN 0
`define BIT_LOW_IRQ_MASK 0
// ********************************************
// reset value and clock select codes
// ********************************************
`define RST_BYTE 8'h00
`define SEL_EXT_FALL 4'h0
`define SEL_EXT_RISE 4'h1
`define SEL_DIV_MIN 4'h6
`define SEL_DIV_MAX 4'hF
// ********************************************
// timing
// ********************************************
`define PRESCALE_W 13
`endif

//--- rtl/cascaded_event_counter.v
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cascade_counter_consts.vh"
module cascaded_event_counter (
   input wire clk_sys,
   input wire rst,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   input wire ext_count_input,
   output reg high_square_out,
   output reg low_square_out,
   output reg low_match_irq,
   output reg high_match_irq
);
   // ********************************************
   // registers
   // ********************************************
   reg [7:0] timer_mode_control_reg;
   reg [7:0] clock_select_reg;
   reg [7:0] output_control_reg;
   reg [7:0] low_compare_reg;
   reg [7:0] high_compare_reg;
   reg [7:0] low_count_reg;
   reg [7:0] high_count_reg;
   reg [7:0] irq_mask_reg;
   reg fast_clock_mode_bit;
   reg lowMatchSticky_reg;
   reg highMatchSticky_reg;
   reg ackPending_reg;
   reg [`PRESCALE_W-1:0] prescale_reg;
   reg [`PRESCALE_W-1:0] prescalePrev_reg;
   reg extSync1_reg;
   reg extSync2_reg;
   reg extPrev_reg;
   wire count_enable_bit;
   wire cascade_mode_bit;
   wire high_output_enable;
   wire lowOutEnable;
   wire low_irq_mask_flag;
   wire [3:0] clock_select_bits;
   assign count_enable_bit = timer_mode_control_reg[`BIT_COUNT_ENABLE];
   assign cascade_mode_bit = timer_mode_control_reg[`BIT_CASCADE_MODE];
   assign high_output_enable = output_control_reg[`BIT_HIGH_OUT_EN];
   assign lowOutEnable = output_control_reg[`BIT_LOW_OUT_EN];
   assign low_irq_mask_flag = irq_mask_reg[`BIT_LOW_IRQ_MASK];
   assign clock_select_bits = clock_select_reg[3:0];
   // ********************************************
   // avalon slave, one wait cycle per access
   // ********************************************
   wire req;
   wire wrTake;
   wire rdTake;
   assign req = read | write;
   assign waitrequest = req & ~ackPending_reg;
   // write lands on the answering edge
   assign wrTake = write & ackPending_reg;
   // read captured on the waiting edge, stands at the answer
   assign rdTake = read & ~ackPending_reg;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ackPending_reg <= 1'b0;
      end else begin
         ackPending_reg <= req & ~ackPending_reg;
      end
   end
   // ********************************************
   // external input synchroniser
   // ********************************************
   // two flip-flops before any logic
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         extSync1_reg <= 1'b0;
         extSync2_reg <= 1'b0;
         extPrev_reg <= 1'b0;
      end else begin
         extSync1_reg <= ext_count_input;
         extSync2_reg <= extSync1_reg;
         extPrev_reg <= extSync2_reg;
      end
   end
   wire extRise;
   wire extFall;
   assign extRise = extSync2_reg & ~extPrev_reg;
   assign extFall = ~extSync2_reg & extPrev_reg;
   // ********************************************
   // prescaler
   // ********************************************
   // free-running divider, taps give enable pulses
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prescale_reg <= {`PRESCALE_W{1'b0}};
         prescalePrev_reg <= {`PRESCALE_W{1'b0}};
      end else begin
         prescale_reg <= prescale_reg + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
         prescalePrev_reg <= prescale_reg;
      end
   end
   // divider tap k: fast mode uses fx/2^(k+1), slow mode fx/2^(k+2)
   reg [3:0] tapIdx;
   reg countTick;
   always @* begin
      tapIdx = 4'h0;
      countTick = 1'b0;
      case (clock_select_bits)
         `SEL_EXT_FALL: begin
            countTick = extFall;
         end
         `SEL_EXT_RISE: begin
            countTick = extRise;
         end
         default: begin
            if (clock_select_bits >= `SEL_DIV_MIN) begin
               tapIdx = clock_select_bits - 4'h6;
               if (clock_select_bits == `SEL_DIV_MAX) begin
                  tapIdx = 4'hA;
               end
               if (!fast_clock_mode_bit) begin
                  tapIdx = tapIdx + 4'h1;
               end
               countTick = prescale_reg[tapIdx] & ~prescalePrev_reg[tapIdx];
            end
         end
      endcase
   end
   // ********************************************
   // counters and match
   // ********************************************
   wire running;
   wire lowMatch;
   wire fullMatch;
   wire lowWrap;
   // counters compare then advance; full match on tick clears both
   wire hitFull;
   wire hitLow;
   assign running = count_enable_bit & cascade_mode_bit;
   assign lowMatch = (low_count_reg == low_compare_reg);
   assign fullMatch = lowMatch & (high_count_reg == high_compare_reg);
   assign lowWrap = (low_count_reg == 8'hFF);
   assign hitFull = running & countTick & fullMatch;
   assign hitLow = running & countTick & lowMatch;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_count_reg <= `RST_BYTE;
         high_count_reg <= `RST_BYTE;
         high_square_out <= 1'b0;
         low_square_out <= 1'b0;
         low_match_irq <= 1'b0;
         high_match_irq <= 1'b0;
      end else begin
         // low irq gated by its mask
         low_match_irq <= hitLow & ~low_irq_mask_flag;
         high_match_irq <= hitFull;
         if (!running) begin
            low_count_reg <= `RST_BYTE;
            high_count_reg <= `RST_BYTE;
         end else if (hitFull) begin
            low_count_reg <= `RST_BYTE;
            high_count_reg <= `RST_BYTE;
         end else if (countTick) begin
            low_count_reg <= low_count_reg + 8'h01;
            if (lowWrap) begin
               high_count_reg <= high_count_reg + 8'h01;
            end
         end
         // high square toggles on the clearing edge, low square on each low match
         if (hitFull && high_output_enable) begin
            high_square_out <= ~high_square_out;
         end
         if (hitLow && lowOutEnable) begin
            low_square_out <= ~low_square_out;
         end
      end
   end
   // ********************************************
   // register writes
   // ********************************************
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         timer_mode_control_reg <= `RST_BYTE;
         clock_select_reg <= `RST_BYTE;
         output_control_reg <= `RST_BYTE;
         low_compare_reg <= `RST_BYTE;
         high_compare_reg <= `RST_BYTE;
         irq_mask_reg <= `RST_BYTE;
         fast_clock_mode_bit <= 1'b0;
      end else begin
         if (wrTake) begin
            case (address)
               `ADDR_MODE_CTRL: begin
                  timer_mode_control_reg <= writedata[7:0];
               end
               `ADDR_CLK_SEL: begin
                  clock_select_reg <= writedata[7:0];
               end
               `ADDR_OUT_CTRL: begin
                  output_control_reg <= writedata[7:0];
               end
               `ADDR_LOW_CMP: begin
                  low_compare_reg <= writedata[7:0];
               end
               `ADDR_HIGH_CMP: begin
                  high_compare_reg <= writedata[7:0];
               end
               `ADDR_STATUS: begin
                  irq_mask_reg <= writedata[15:8];
               end
               `ADDR_FAST_CLK: begin
                  fast_clock_mode_bit <= writedata[0];
               end
               default: begin
               end
            endcase
         end
      end
   end
   // ********************************************
   // sticky flags
   // ********************************************
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowMatchSticky_reg <= 1'b0;
         highMatchSticky_reg <= 1'b0;
      end else begin
         // write-one-to-clear, a new event wins over the clear
         if (wrTake && address == `ADDR_STATUS && writedata[0]) begin
            lowMatchSticky_reg <= 1'b0;
         end
         if (wrTake && address == `ADDR_STATUS && writedata[1]) begin
            highMatchSticky_reg <= 1'b0;
         end
         if (hitLow) begin
            lowMatchSticky_reg <= 1'b1;
         end
         if (hitFull) begin
            highMatchSticky_reg <= 1'b1;
         end
      end
   end
   // ********************************************
   // read data, count captured whole in one word
   // ********************************************
   // unmapped indices read zero
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (rdTake) begin
         case (address)
            `ADDR_MODE_CTRL: begin
               readdata <= {24'h000000, timer_mode_control_reg};
            end
            `ADDR_CLK_SEL: begin
               readdata <= {24'h000000, clock_select_reg};
            end
            `ADDR_OUT_CTRL: begin
               readdata <= {24'h000000, output_control_reg};
            end
            `ADDR_LOW_CMP: begin
               readdata <= {24'h000000, low_compare_reg};
            end
            `ADDR_HIGH_CMP: begin
               readdata <= {24'h000000, high_compare_reg};
            end
            `ADDR_COUNT: begin
               readdata <= {16'h0000, high_count_reg, low_count_reg};
            end
            `ADDR_STATUS: begin
               readdata <= {16'h0000, irq_mask_reg, 6'h00, highMatchSticky_reg, lowMatchSticky_reg};
            end
            `ADDR_FAST_CLK: begin
               readdata <= {31'h00000000, fast_clock_mode_bit};
            end
            default: begin
               readdata <= 32'h00000000;
            end
         endcase
      end
   end
endmodule

//--- sim/ext_event_source.sv
`timescale 1ns/1ps
// ****
// event source and square load
// ****
module ext_event_source (
   input wire clk_sys,
   input wire high_square_out,
   output logic ext_count_input = 1'h0
);
   int toggles = 0;
   task automatic burst(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_sys);
         ext_count_input <= ~ext_count_input;
      end
   endtask
   always @(high_square_out) toggles++;
endmodule

//--- sim/cascaded_event_counter_sva.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module cascaded_event_counter_sva (
   input wire clk_sys,
   input wire rst,
   input wire read,
   input wire write,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire high_square_out,
   input wire low_square_out,
   input wire low_match_irq,
   input wire high_match_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_wait; (read || write) && waitrequest; endsequence
   sequence s_ack; (read || write) && !waitrequest; endsequence
   a_wait_one: assert property (s_wait |=> s_ack) else $error("late answer");
   a_wait_first: assert property ((read || write) && !$past(read || write) |-> s_wait) else $error("no wait");
   a_wait_idle: assert property (!read && !write |-> !waitrequest) else $error("idle wait");
   a_data_hold: assert property ($changed(readdata) |-> $past(read)) else $error("data moved");
   a_high_pulse: assert property (high_match_irq |=> !high_match_irq) else $error("long irq");
   a_low_pulse: assert property (low_match_irq |=> !low_match_irq) else $error("long irq");
   a_square_match: assert property ($changed(high_square_out) |-> high_match_irq) else $error("stray");
   a_reset_quiet: assert property ($past(rst) |-> !high_match_irq && !low_match_irq && !high_square_out
      && !low_square_out) else $error("busy after reset");
endmodule
bind cascaded_event_counter cascaded_event_counter_sva i_chk (.*);

//--- sim/cascaded_event_counter_bench.sv
`timescale 1ns/1ps
`include "cascade_counter_consts.vh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %0h %0h", $time, g, e); end end
// ****
// bench
// ****
module cascaded_event_counter_bench;
   typedef struct {logic [3:0] sel; logic [15:0] cmp; logic [7:0] oc; logic msk; int n; logic [15:0] cnt;
      int hi; int lo; int sq;} row_t;
   row_t rows [5] = '{'{4'h1, 16'h0000, 8'h11, 1'h0, 10, 16'h0000, 5, 5, 5},
      '{4'h0, 16'h0002, 8'h11, 1'h1, 9, 16'h0001, 1, 0, 1}, '{4'h1, 16'h0002, 8'h00, 1'h0, 9, 16'h0001, 1, 1, 0},
      '{4'h1, 16'h0102, 8'h10, 1'h1, 600, 16'h0029, 1, 0, 1}, '{4'h0, 16'h0000, 8'h10, 1'h1, 6, 16'h0000, 3, 0, 3}};
   logic clk_sys, rst, read, write;
   logic [3:0] address;
   logic [31:0] writedata, q;
   wire [31:0] readdata;
   wire waitrequest, ext_count_input, high_square_out, low_square_out, low_match_irq, high_match_irq;
   int mismatches = 0, nTests = 0, cyc = 0, hiCnt = 0, loCnt = 0, h0, l0, s0;
   time t [2];
   cascaded_event_counter i_cascaded_event_counter (.*);
   ext_event_source i_ext_event_source (.*);
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      hiCnt += high_match_irq;
      loCnt += low_match_irq;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize;
      $display("tests %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge clk_sys); while (waitrequest);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic run(input int n);
      i_ext_event_source.burst(n);
      repeat (8) @(posedge clk_sys);
      bus(1'h0, `ADDR_COUNT, 32'h0);
   endtask
   initial begin
      rst = 1'h1;
      read = 1'h0;
      write = 1'h0;
      address = 4'h0;
      writedata = 32'h0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'h0;
      foreach (rows[i]) begin
         bus(1'h1, `ADDR_MODE_CTRL, 32'h0);
         bus(1'h1, `ADDR_CLK_SEL, rows[i].sel);
         bus(1'h1, `ADDR_OUT_CTRL, rows[i].oc);
         bus(1'h1, `ADDR_LOW_CMP, rows[i].cmp[7:0]);
         bus(1'h1, `ADDR_HIGH_CMP, rows[i].cmp[15:8]);
         bus(1'h1, `ADDR_STATUS, {rows[i].msk, 8'h03});
         h0 = hiCnt;
         l0 = loCnt;
         s0 = i_ext_event_source.toggles;
         bus(1'h1, `ADDR_MODE_CTRL, 32'h5);
         run(rows[i].n);
         `CHK(q[15:0], rows[i].cnt)
         `CHK(hiCnt - h0, rows[i].hi)
         `CHK(loCnt - l0, rows[i].lo)
         `CHK(i_ext_event_source.toggles - s0, rows[i].sq)
         $display("row %0d done", i);
      end
      for (int i = 0; i < 2; i++) begin
         bus(1'h1, `ADDR_MODE_CTRL, 32'h0);
         bus(1'h1, `ADDR_FAST_CLK, {31'h0, i == 0});
         bus(1'h1, `ADDR_CLK_SEL, `SEL_DIV_MIN);
         bus(1'h1, `ADDR_LOW_CMP, 9 * i);
         bus(1'h1, `ADDR_MODE_CTRL, 32'h5);
         foreach (t[k]) begin
            do @(posedge clk_sys); while (high_match_irq !== 1'h1);
            t[k] = $time;
         end
         `CHK(t[1] - t[0], (9 * i + 1) * (2 + 2 * i) * 100)
         $display("clock %0d done", i);
      end
      bus(1'h1, `ADDR_MODE_CTRL, 32'h1);
      bus(1'h1, `ADDR_CLK_SEL, `SEL_EXT_RISE);
      bus(1'h1, `ADDR_LOW_CMP, 32'h5);
      run(2);
      `CHK(q[15:0], 16'h0000)
      h0 = hiCnt;
      bus(1'h1, `ADDR_MODE_CTRL, 32'h5);
      run(8);
      bus(1'h1, `ADDR_LOW_CMP, 32'h2);
      run(8);
      `CHK(q[15:0], 16'h0008)
      `CHK(hiCnt - h0, 0)
      bus(1'h1, `ADDR_MODE_CTRL, 32'h0);
      run(0);
      `CHK(q[15:0], 16'h0000)
      $display("compare change done");
      bus(1'h1, 4'h9, 32'hFF);
      bus(1'h0, 4'h9, 32'h0);
      `CHK(q, 32'h0)
      bus(1'h1, `ADDR_MODE_CTRL, 32'h5);
      rst <= 1'h1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'h0;
      bus(1'h0, `ADDR_MODE_CTRL, 32'h0);
      `CHK(q, 32'h0)
      $display("reset done");
      summarize();
   end
endmodule
